// [rtl/rm_pkg.sv]
package rm_pkg;

    // ******************************************************
    // Register offsets (byte addresses on the register bus)
    // ******************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_CODE_SEL = 8'h08;
    localparam logic [7:0] OFS_INSTR_PTR = 8'h0c;
    localparam logic [7:0] OFS_STACK_SEL = 8'h10;
    localparam logic [7:0] OFS_STACK_PTR = 8'h14;
    localparam logic [7:0] OFS_TABLE_BASE = 8'h18;
    localparam logic [7:0] OFS_TABLE_LIMIT = 8'h1c;
    localparam logic [7:0] OFS_COMMAND = 8'h20;

    // ******************************************************
    // Field positions and reset values
    // ******************************************************
    localparam int CMD_VEC_LSB = 0;
    localparam int CMD_RAISE_BIT = 8;
    localparam int CMD_INTERRUPT_RETURN_INSTRUCTION_BIT = 9;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_A20_BIT = 1;
    localparam int ST_LASTVEC_LSB = 8;
    localparam int FLAG_IF_BIT = 9;
    localparam int FLAG_TF_BIT = 8;
    localparam logic [31:0] TABLE_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] TABLE_LIMIT_RST = 16'h03ff;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
    localparam logic [15:0] CODE_SEL_RST = 16'hf000;
    localparam logic [31:0] INSTR_PTR_RST = 32'h0000_fff0;
    localparam logic [31:0] OFFSET_MAX = 32'h0000_ffff;
    localparam int SEL_SHIFT = 4;
    localparam int ENTRY_SHIFT = 2;
    localparam logic [15:0] WORD_BYTES = 16'h0002;

    // ******************************************************
    // Vectors
    // ******************************************************
    localparam logic [7:0] VEC_UD = 8'h06;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_SS = 8'h0c;
    localparam logic [7:0] VEC_GP = 8'h0d;
    localparam logic [7:0] VEC_LAST_EXC = 8'h08;
    localparam logic [7:0] VEC_MF = 8'h10;
    localparam logic [7:0] VEC_MC = 8'h12;
    localparam logic [7:0] VEC_USER_FIRST = 8'h20;

    typedef enum logic [1:0] {
        CLS_CORE = 2'h0,
        CLS_LATER = 2'h1,
        CLS_OTHER = 2'h2
    } instr_class_t;

    typedef enum logic [10:0] {
        ST_IDLE = 11'h001,
        ST_PUSH_CS = 11'h002,
        ST_PUSH_IP = 11'h004,
        ST_PUSH_FL = 11'h008,
        ST_CLR_IF = 11'h010,
        ST_CLR_TF = 11'h020,
        ST_RD_OFF = 11'h040,
        ST_RD_SEL = 11'h080,
        ST_POP_IP = 11'h100,
        ST_POP_CS = 11'h200,
        ST_POP_FL = 11'h400
    } fsm_t;

    // ******************************************************
    // Carriers
    // ******************************************************
    typedef struct packed {
        logic valid;
        logic stack;
        logic [15:0] sel;
        logic [31:0] offset;
    } xlat_req_t;

    typedef struct packed {
        logic fault;
        logic [20:0] phys;
    } xlat_res_t;

    typedef struct packed {
        logic valid;
        instr_class_t cls;
        logic opsize_pfx;
    } dec_req_t;

    typedef struct packed {
        logic invalid;
        logic wide32;
    } dec_res_t;

    typedef struct packed {
        logic cyc;
        logic we;
        logic [31:0] adr;
        logic [15:0] dat;
    } mem_req_t;

endpackage : rm_pkg

// [rtl/real_mode_addr_and_interrupt.sv]
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module real_mode_addr_and_interrupt (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic address_bit20_mask_input_i,
    input wire logic nmi_i,
    input wire logic intr_i,
    input wire logic [7:0] intr_vec_i,
    input wire logic exc_req_i,
    input wire logic [7:0] exc_vec_i,
    input wire rm_pkg::xlat_req_t xlat_i,
    output rm_pkg::xlat_res_t xlat_o,
    input wire rm_pkg::dec_req_t dec_i,
    output rm_pkg::dec_res_t dec_o,
    output rm_pkg::mem_req_t mem_o,
    input wire logic [15:0] mem_dat_i,
    input wire logic mem_ack_i,
    output logic busy_o
);

    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed {
        rm_pkg::fsm_t st;
        logic [31:0] flags;
        logic [15:0] cs;
        logic [31:0] ip;
        logic [15:0] ss;
        logic [15:0] sp;
        logic [31:0] tbase;
        logic [15:0] tlimit;
        logic [7:0] vec;
        logic [7:0] last_vec;
        logic pend_v;
        logic [7:0] pend_vec;
        logic [15:0] hoff;
        logic a20_s1;
        logic a20_s2;
        logic nmi_s1;
        logic nmi_s2;
        logic nmi_s3;
        logic intr_s1;
        logic intr_s2;
        logic [7:0] ivec_s1;
        logic [7:0] ivec_s2;
        logic wb_ack;
        logic [31:0] wb_dat;
        rm_pkg::xlat_res_t xlat;
        rm_pkg::dec_res_t dec;
        rm_pkg::mem_req_t mem;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ******************************************************
    // Helpers
    // ******************************************************

    // Real-mode physical address; 21 bits so the carry survives
    function automatic logic [20:0] phys_of(input logic [15:0] sel,
                                            input logic [15:0] off,
                                            input logic mask);
        logic [20:0] sum;
        sum = {1'b0, sel, 4'h0} + {5'h00, off};
        if (mask) begin
            sum[20] = 1'b0;
        end
        return sum;
    endfunction : phys_of

    // Vectors that an exception request on exc_req_i may raise; the raise command is not checked
    function automatic logic vec_ok(input logic [7:0] v);
        return (v <= rm_pkg::VEC_LAST_EXC) || (v == rm_pkg::VEC_SS) ||
               (v == rm_pkg::VEC_GP) || (v == rm_pkg::VEC_MF) ||
               (v == rm_pkg::VEC_MC) || (v >= rm_pkg::VEC_USER_FIRST);
    endfunction : vec_ok

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // One 16-bit memory cycle request
    function automatic rm_pkg::mem_req_t mreq(input logic [31:0] adr,
                                              input logic we,
                                              input logic [15:0] dat);
        rm_pkg::mem_req_t m;
        m.cyc = 1'b1;
        m.we = we;
        m.adr = adr;
        m.dat = dat;
        return m;
    endfunction : mreq

    // ******************************************************
    // Next-state logic
    // ******************************************************
    logic wb_hit;
    logic wb_wr;
    logic idle;
    logic done;
    logic ev_v;
    logic [7:0] ev_vec;
    logic [15:0] sp_dn;
    logic [31:0] stk_dn;
    logic [31:0] tent;
    logic [31:0] wv;

    always_comb begin
        state_next = state_reg;
        idle = (state_reg.st == rm_pkg::ST_IDLE);
        done = state_reg.mem.cyc & mem_ack_i;
        sp_dn = state_reg.sp - rm_pkg::WORD_BYTES;
        stk_dn = {11'h000, phys_of(state_reg.ss, sp_dn, state_reg.a20_s2)};
        tent = state_reg.tbase +
               {22'h000000, state_reg.vec, 2'h0};
        ev_v = 1'b0;
        ev_vec = 8'h00;
        wv = 32'h0000_0000;

        // Pin synchronisers; second stages feed logic, and nmi_s3 for the NMI edge
        state_next.a20_s1 = address_bit20_mask_input_i;
        state_next.a20_s2 = state_reg.a20_s1;
        state_next.nmi_s1 = nmi_i;
        state_next.nmi_s2 = state_reg.nmi_s1;
        state_next.nmi_s3 = state_reg.nmi_s2;
        state_next.intr_s1 = intr_i;
        state_next.intr_s2 = state_reg.intr_s1;
        state_next.ivec_s1 = intr_vec_i;
        state_next.ivec_s2 = state_reg.ivec_s1;

        // Register bus: ack one cycle after strobe, then drop
        wb_hit = wb_cyc_i & wb_stb_i & ~state_reg.wb_ack;
        wb_wr = wb_hit & wb_we_i;
        state_next.wb_ack = wb_hit;
        if (wb_hit) begin
            case (wb_adr_i)
                rm_pkg::OFS_STATUS: begin
                    wv[rm_pkg::ST_BUSY_BIT] = ~idle;
                    wv[rm_pkg::ST_A20_BIT] = state_reg.a20_s2;
                    wv[rm_pkg::ST_LASTVEC_LSB +: 8] = state_reg.last_vec;
                end
                rm_pkg::OFS_FLAGS: wv = state_reg.flags;
                rm_pkg::OFS_CODE_SEL: wv = {16'h0000, state_reg.cs};
                rm_pkg::OFS_INSTR_PTR: wv = state_reg.ip;
                rm_pkg::OFS_STACK_SEL: wv = {16'h0000, state_reg.ss};
                rm_pkg::OFS_STACK_PTR: wv = {16'h0000, state_reg.sp};
                rm_pkg::OFS_TABLE_BASE: wv = state_reg.tbase;
                rm_pkg::OFS_TABLE_LIMIT: wv = {16'h0000, state_reg.tlimit};
                default: wv = 32'h0000_0000;
            endcase
            state_next.wb_dat = wv;
        end

        // Software writes; the sequencer owns the state while busy
        if (wb_wr & idle) begin
            case (wb_adr_i)
                rm_pkg::OFS_FLAGS: begin
                    state_next.flags = merge(state_reg.flags, wb_dat_i,
                                             wb_sel_i);
                end
                rm_pkg::OFS_CODE_SEL: begin
                    state_next.cs = 16'(merge({16'h0000, state_reg.cs},
                                              wb_dat_i, wb_sel_i));
                end
                rm_pkg::OFS_INSTR_PTR: begin
                    state_next.ip = merge(state_reg.ip, wb_dat_i, wb_sel_i);
                end
                rm_pkg::OFS_STACK_SEL: begin
                    state_next.ss = 16'(merge({16'h0000, state_reg.ss},
                                              wb_dat_i, wb_sel_i));
                end
                rm_pkg::OFS_STACK_PTR: begin
                    state_next.sp = 16'(merge({16'h0000, state_reg.sp},
                                              wb_dat_i, wb_sel_i));
                end
                rm_pkg::OFS_TABLE_BASE: begin
                    state_next.tbase = merge(state_reg.tbase, wb_dat_i,
                                             wb_sel_i);
                end
                rm_pkg::OFS_TABLE_LIMIT: begin
                    state_next.tlimit = 16'(merge({16'h0000,
                                                   state_reg.tlimit},
                                                  wb_dat_i, wb_sel_i));
                end
                rm_pkg::OFS_COMMAND: begin
                    if (wb_sel_i[1] & wb_dat_i[rm_pkg::CMD_INTERRUPT_RETURN_INSTRUCTION_BIT]) begin
                        state_next.st = rm_pkg::ST_POP_IP;
                    end
                end
                default: begin
                end
            endcase
        end

        // Address translation, one cycle latency
        state_next.xlat.fault = 1'b0;
        if (xlat_i.valid) begin
            state_next.xlat.phys = phys_of(xlat_i.sel, xlat_i.offset[15:0],
                                           state_reg.a20_s2);
            if (xlat_i.offset > rm_pkg::OFFSET_MAX) begin
                state_next.xlat.fault = 1'b1;
                ev_v = 1'b1;
                ev_vec = xlat_i.stack ? rm_pkg::VEC_SS : rm_pkg::VEC_GP;
            end
        end

        // Decode check, one cycle latency
        state_next.dec.invalid = 1'b0;
        if (dec_i.valid) begin
            state_next.dec.wide32 = dec_i.opsize_pfx;
            if (dec_i.cls != rm_pkg::CLS_CORE &&
                dec_i.cls != rm_pkg::CLS_LATER) begin
                state_next.dec.invalid = 1'b1;
                ev_v = 1'b1;
                ev_vec = rm_pkg::VEC_UD;
            end
        end

        // Other internal sources, lower priority than faults above
        if (!ev_v && exc_req_i && vec_ok(exc_vec_i)) begin
            ev_v = 1'b1;
            ev_vec = exc_vec_i;
        end
        if (!ev_v && wb_wr && wb_adr_i == rm_pkg::OFS_COMMAND &&
            wb_sel_i[1] && wb_dat_i[rm_pkg::CMD_RAISE_BIT]) begin
            ev_v = 1'b1;
            ev_vec = wb_dat_i[rm_pkg::CMD_VEC_LSB +: 8];
        end

        // Sequencer
        case (state_reg.st)
            rm_pkg::ST_IDLE: begin
                // A return command written this cycle must not be lost
                if (state_next.st != rm_pkg::ST_IDLE) begin
                end else if (state_reg.pend_v) begin
                    state_next.pend_v = 1'b0;
                    state_next.vec = state_reg.pend_vec;
                    state_next.st = rm_pkg::ST_PUSH_CS;
                end else if (state_reg.nmi_s2 & ~state_reg.nmi_s3) begin
                    state_next.vec = rm_pkg::VEC_NMI;
                    state_next.st = rm_pkg::ST_PUSH_CS;
                end else if (state_reg.intr_s2 &&
                             state_reg.flags[rm_pkg::FLAG_IF_BIT] &&
                             state_reg.ivec_s2 >= rm_pkg::VEC_USER_FIRST &&
                             state_next.st == rm_pkg::ST_IDLE) begin
                    state_next.vec = state_reg.ivec_s2;
                    state_next.st = rm_pkg::ST_PUSH_CS;
                end
            end
            rm_pkg::ST_PUSH_CS: begin
                state_next.mem = mreq(stk_dn, 1'b1, state_reg.cs);
                if (done) begin
                    state_next.sp = sp_dn;
                    state_next.st = rm_pkg::ST_PUSH_IP;
                end
            end
            rm_pkg::ST_PUSH_IP: begin
                state_next.mem = mreq(stk_dn, 1'b1, state_reg.ip[15:0]);
                if (done) begin
                    state_next.sp = sp_dn;
                    state_next.st = rm_pkg::ST_PUSH_FL;
                end
            end
            rm_pkg::ST_PUSH_FL: begin
                state_next.mem = mreq(stk_dn, 1'b1, state_reg.flags[15:0]);
                if (done) begin
                    state_next.sp = sp_dn;
                    state_next.st = rm_pkg::ST_CLR_IF;
                end
            end
            rm_pkg::ST_CLR_IF: begin
                state_next.flags[rm_pkg::FLAG_IF_BIT] = 1'b0;
                state_next.st = rm_pkg::ST_CLR_TF;
            end
            rm_pkg::ST_CLR_TF: begin
                state_next.flags[rm_pkg::FLAG_TF_BIT] = 1'b0;
                state_next.st = rm_pkg::ST_RD_OFF;
            end
            rm_pkg::ST_RD_OFF: begin
                state_next.mem = mreq(tent, 1'b0, 16'h0000);
                if (done) begin
                    state_next.hoff = mem_dat_i;
                    state_next.st = rm_pkg::ST_RD_SEL;
                end
            end
            rm_pkg::ST_RD_SEL: begin
                state_next.mem = mreq(tent + 32'h0000_0002, 1'b0,
                                      16'h0000);
                if (done) begin
                    state_next.cs = mem_dat_i;
                    state_next.ip = {16'h0000, state_reg.hoff};
                    state_next.last_vec = state_reg.vec;
                    state_next.st = rm_pkg::ST_IDLE;
                end
            end
            rm_pkg::ST_POP_IP: begin
                state_next.mem = mreq({11'h000, phys_of(state_reg.ss,
                    state_reg.sp + 16'h0002, state_reg.a20_s2)},
                    1'b0, 16'h0000);
                if (done) begin
                    state_next.ip = {16'h0000, mem_dat_i};
                    state_next.st = rm_pkg::ST_POP_CS;
                end
            end
            rm_pkg::ST_POP_CS: begin
                state_next.mem = mreq({11'h000, phys_of(state_reg.ss,
                    state_reg.sp + 16'h0004, state_reg.a20_s2)},
                    1'b0, 16'h0000);
                if (done) begin
                    state_next.cs = mem_dat_i;
                    state_next.st = rm_pkg::ST_POP_FL;
                end
            end
            rm_pkg::ST_POP_FL: begin
                state_next.mem = mreq({11'h000, phys_of(state_reg.ss,
                    state_reg.sp, state_reg.a20_s2)}, 1'b0, 16'h0000);
                if (done) begin
                    state_next.flags[15:0] = mem_dat_i;
                    state_next.sp = state_reg.sp + 16'h0006;
                    state_next.st = rm_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next.st = rm_pkg::ST_IDLE;
            end
        endcase

        // Gap cycle after each ack keeps the bus classic
        if (done || !state_reg.mem.cyc && state_reg.mem.adr == 32'h0 &&
            1'b0) begin
            state_next.mem.cyc = 1'b0;
        end
        if (idle || state_next.st == rm_pkg::ST_CLR_IF ||
            state_next.st == rm_pkg::ST_CLR_TF) begin
            state_next.mem.cyc = state_reg.st == rm_pkg::ST_IDLE ?
                                 1'b0 : state_next.mem.cyc & ~done;
        end

        // Pending event; a new event is queued after the take above, dropped if one stays pending
        if (ev_v && !state_next.pend_v) begin
            state_next.pend_v = 1'b1;
            state_next.pend_vec = ev_vec;
        end
    end

    // ******************************************************
    // State register
    // ******************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.st <= rm_pkg::ST_IDLE;
            state_reg.flags <= rm_pkg::FLAGS_RST;
            state_reg.cs <= rm_pkg::CODE_SEL_RST;
            state_reg.ip <= rm_pkg::INSTR_PTR_RST;
            state_reg.tbase <= rm_pkg::TABLE_BASE_RST;
            state_reg.tlimit <= rm_pkg::TABLE_LIMIT_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign wb_ack_o = state_reg.wb_ack;
    assign wb_dat_o = state_reg.wb_dat;
    assign xlat_o = state_reg.xlat;
    assign dec_o = state_reg.dec;
    assign mem_o = state_reg.mem;
    assign busy_o = ~(state_reg.st == rm_pkg::ST_IDLE);

endmodule : real_mode_addr_and_interrupt

// [sim/rm_sva.sv]
`timescale 1ns/1ps
module rm_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic address_bit20_mask_input_i,
    input wire rm_pkg::xlat_req_t xlat_i,
    input wire rm_pkg::xlat_res_t xlat_o,
    input wire rm_pkg::dec_req_t dec_i,
    input wire rm_pkg::dec_res_t dec_o
);
    // ********
    // Checks
    // ********
    logic [20:0] sum_reg;
    logic ok_off;
    // Wide sum so a lost carry shows
    always_ff @(posedge clk_i) begin
        sum_reg <= {1'h0, xlat_i.sel, 4'h0} + {5'h0, xlat_i.offset[15:0]};
    end
    assign ok_off = xlat_i.valid && xlat_i.offset[31:16] == 16'h0;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Held past the input synchroniser
    sequence mask_on;
        address_bit20_mask_input_i [*4];
    endsequence
    sequence mask_off;
        !address_bit20_mask_input_i [*4];
    endsequence
    phys_sum_a: assert property (
        ok_off |=> xlat_o.phys[19:0] == sum_reg[19:0])
        else $error("bad address");
    carry_keep_a: assert property (
        mask_off ##0 ok_off |=> xlat_o.phys[20] == sum_reg[20])
        else $error("carry lost");
    mask_low_a: assert property (
        mask_on ##0 ok_off |=> !xlat_o.phys[20])
        else $error("bit 20 not masked");
    range_fault_a: assert property (
        xlat_i.valid && !ok_off |=> xlat_o.fault)
        else $error("no range fault");
    no_fault_a: assert property (
        ok_off |=> !xlat_o.fault)
        else $error("false fault");
    bad_op_a: assert property (
        dec_i.valid && dec_i.cls == rm_pkg::CLS_OTHER |=> dec_o.invalid)
        else $error("bad opcode passed");
    good_op_a: assert property (
        dec_i.valid && dec_i.cls != rm_pkg::CLS_OTHER |=> !dec_o.invalid)
        else $error("good opcode refused");
    wide_op_a: assert property (
        dec_i.valid |=> dec_o.wide32 == $past(dec_i.opsize_pfx))
        else $error("size prefix lost");
endmodule : rm_sva

bind real_mode_addr_and_interrupt rm_sva u_sva (.clk_i, .rst_i,
    .address_bit20_mask_input_i, .xlat_i, .xlat_o, .dec_i, .dec_o);

// [sim/rm_mem.sv]
`timescale 1ns/1ps
module rm_mem (
    input wire logic clk_i,
    input wire rm_pkg::mem_req_t mem_i,
    output logic [15:0] dat_o = 16'h0,
    output logic ack_o = 1'h0
);
    logic [15:0] m [logic [31:0]];
    int wait_cnt = 0;
    int slow = 0;
    // Alternates prompt and slow answers; data churns when idle
    always @(posedge clk_i) begin
        ack_o <= 1'h0;
        dat_o <= ~dat_o;
        if (mem_i.cyc && !ack_o && wait_cnt < slow) wait_cnt <= wait_cnt + 1;
        else if (mem_i.cyc && !ack_o) begin
            ack_o <= 1'h1;
            wait_cnt <= 0;
            slow <= 2 - slow;
            if (mem_i.we) m[mem_i.adr] = mem_i.dat;
            else dat_o <= m.exists(mem_i.adr) ? m[mem_i.adr] : 16'h0;
        end
    end
endmodule : rm_mem

// [sim/real_mode_addr_and_interrupt_tb.sv]
`timescale 1ns/1ps
module real_mode_addr_and_interrupt_tb;
    logic clk_i = 1'h0, rst_i = 1'h1, intr_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h0, intr_vec_i = 8'h20;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, busy_o, mem_ack_i, address_bit20_mask_input_i = 1'h0;
    logic nmi_i = 1'h0, exc_req_i = 1'h0;
    logic [7:0] exc_vec_i = 8'h0;
    logic [15:0] mem_dat_i;
    rm_pkg::xlat_req_t xlat_i = '0;
    rm_pkg::xlat_res_t xlat_o;
    rm_pkg::dec_req_t dec_i = '0;
    rm_pkg::dec_res_t dec_o;
    rm_pkg::mem_req_t mem_o;
    int bad_count = 0, total_checks = 0, ticks = 0;
    real_mode_addr_and_interrupt DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .address_bit20_mask_input_i, .nmi_i, .intr_i, .intr_vec_i,
        .exc_req_i, .exc_vec_i, .xlat_i, .xlat_o, .dec_i, .dec_o,
        .mem_o, .mem_dat_i, .mem_ack_i, .busy_o);
    rm_mem u_mem (.clk_i, .mem_i(mem_o), .dat_o(mem_dat_i), .ack_o(mem_ack_i));
    // ********
    // Tasks
    // ********
    always #25 clk_i = ~clk_i;
    // Hang guard
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 6000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // Held until ack is sampled, released after
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'h1) @(posedge clk_i);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic rdck(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask : rdck
    task automatic mck(input logic [31:0] a, input logic [15:0] e);
        chk({16'h0, u_mem.m[a]}, {16'h0, e});
    endtask : mck
    // Fault case compares only the fault bit
    task automatic xl(input logic s, input logic [15:0] sl,
                      input logic [31:0] o, input logic [21:0] e);
        @(posedge clk_i);
        xlat_i <= '{1'h1, s, sl, o};
        @(posedge clk_i);
        xlat_i.valid <= 1'h0;
        @(posedge clk_i);
        chk({10'h0, xlat_o} & (e[21] ? 32'h20_0000 : 32'h3f_ffff), {10'h0, e});
    endtask : xl
    task automatic settle();
        int idle;
        idle = 0;
        while (idle < 6) begin
            @(posedge clk_i);
            idle = (busy_o === 1'h0) ? idle + 1 : 0;
        end
    endtask : settle
    // ********
    // Tests
    // ********
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        rdck(rm_pkg::OFS_TABLE_BASE, 32'h0);
        rdck(rm_pkg::OFS_TABLE_LIMIT, 32'h3ff);
        wb(1'h1, 8'hfc, 32'hffff_ffff);
        rdck(8'hfc, 32'h0);
        wb(1'h1, rm_pkg::OFS_TABLE_BASE, 32'h200);
        rdck(rm_pkg::OFS_TABLE_BASE, 32'h200);
        wb(1'h1, rm_pkg::OFS_STACK_PTR, 32'h100);
        wb(1'h1, rm_pkg::OFS_FLAGS, 32'h302);
        xl(1'h0, 16'hffff, 32'hffff, 22'h10_ffef);
        xl(1'h0, 16'h1234, 32'h5, 22'h01_2345);
        address_bit20_mask_input_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        xl(1'h0, 16'hffff, 32'hffff, 22'h0_ffef);
        address_bit20_mask_input_i <= 1'h0;
        {u_mem.m[32'h230], u_mem.m[32'h232]} = 32'h1234_5678;
        {u_mem.m[32'h300], u_mem.m[32'h302]} = 32'haaaa_bbbb;
        u_mem.m[32'hf8] = 16'h5a5a;
        xl(1'h1, 16'h0, 32'h1_0000, 22'h20_0000);
        settle();
        mck(32'hfe, 16'hf000);
        mck(32'hfc, 16'hfff0);
        mck(32'hfa, 16'h0302);
        mck(32'hf8, 16'h5a5a);
        rdck(rm_pkg::OFS_FLAGS, 32'h2);
        rdck(rm_pkg::OFS_CODE_SEL, 32'h5678);
        rdck(rm_pkg::OFS_INSTR_PTR, 32'h1234);
        rdck(rm_pkg::OFS_STACK_PTR, 32'hfa);
        {u_mem.m[32'hfa], u_mem.m[32'hfc], u_mem.m[32'hfe]} = 48'h0202_4444_3333;
        {intr_vec_i, intr_i} <= {8'h40, 1'h1};
        settle();
        rdck(rm_pkg::OFS_STATUS, 32'h0c00);
        wb(1'h1, rm_pkg::OFS_COMMAND, 32'h200);
        settle();
        intr_i <= 1'h0;
        mck(32'hfe, 16'h3333);
        mck(32'hfc, 16'h4444);
        rdck(rm_pkg::OFS_CODE_SEL, 32'hbbbb);
        rdck(rm_pkg::OFS_STATUS, 32'h4000);
        for (int c = 0; c < 3; c++) begin
            @(posedge clk_i);
            dec_i <= '{1'h1, rm_pkg::instr_class_t'(c), c[0]};
            @(posedge clk_i);
            dec_i.valid <= 1'h0;
            @(posedge clk_i);
            chk({30'h0, dec_o}, {30'h0, c == 2, c[0]});
        end
        settle();
        rdck(rm_pkg::OFS_STATUS, 32'h0600);
        // Non-maskable edge is taken with enable clear
        nmi_i <= 1'h1;
        settle();
        nmi_i <= 1'h0;
        rdck(rm_pkg::OFS_STATUS, 32'h0200);
        // Reserved vector dropped, floating-point error taken
        @(posedge clk_i);
        {exc_req_i, exc_vec_i} <= {1'h1, 8'h0a};
        @(posedge clk_i);
        exc_req_i <= 1'h0;
        settle();
        rdck(rm_pkg::OFS_STATUS, 32'h0200);
        @(posedge clk_i);
        {exc_req_i, exc_vec_i} <= {1'h1, 8'h10};
        @(posedge clk_i);
        exc_req_i <= 1'h0;
        settle();
        rdck(rm_pkg::OFS_STATUS, 32'h1000);
        complete_run();
    end
endmodule : real_mode_addr_and_interrupt_tb
